// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cdu_pkg::*;
  logic CLK, RST_N, CE, IO_WR, IO_RD; // Clock, reset and strobes
  logic [15:0] IO_ADDR, IO_WDATA, IO_RDATA; // Port bus
  logic EXT_CLOCK_OUT, USB_DIGITAL_EN, USB_ANALOG_EN; // Clock outputs
  logic ANALOG_PHASE_LOOP_DIV_SEL, ANALOG_PHASE_LOOP_VCO_ON, ANALOG_PHASE_LOOP_MULTIPLY_MODE; // Loop controls
  logic [3:0] ANALOG_PHASE_LOOP_LOOP_MULTIPLY_FIELD; // Loop multiply field
  logic [15:0] r, c0; // Read results
  int failures, check_count, seed, i, k, m; // Counters and random words
  realtime t0; // Start of a measured output period

  cdu_clock_ctrl dut_u (.CLK(CLK), .RST_N(RST_N), .CE(CE), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR),
    .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .EXT_CLOCK_OUT(EXT_CLOCK_OUT),
    .USB_DIGITAL_EN(USB_DIGITAL_EN), .USB_ANALOG_EN(USB_ANALOG_EN), .ANALOG_PHASE_LOOP_LOOP_MULTIPLY_FIELD(ANALOG_PHASE_LOOP_LOOP_MULTIPLY_FIELD),
    .ANALOG_PHASE_LOOP_DIV_SEL(ANALOG_PHASE_LOOP_DIV_SEL), .ANALOG_PHASE_LOOP_VCO_ON(ANALOG_PHASE_LOOP_VCO_ON),
    .ANALOG_PHASE_LOOP_MULTIPLY_MODE(ANALOG_PHASE_LOOP_MULTIPLY_MODE));

  // CPU clock at 40 MHz
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // Compare one value, report and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One-cycle write strobe, driven on the falling edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge CLK);
    IO_ADDR = a;
    IO_WDATA = d;
    IO_WR = 1'b1;
    @(negedge CLK);
    IO_WR = 1'b0;
  endtask : wr

  // One-cycle read strobe; data is settled by the next falling edge
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge CLK);
    IO_ADDR = a;
    IO_RD = 1'b1;
    @(negedge CLK);
    IO_RD = 1'b0;
    d = IO_RDATA;
  endtask : rd

  // Expected output divisor for a divide code
  function automatic int divisor(input logic [2:0] c);
    return (c == 3'h0) ? 1 : 2 * int'(c);
  endfunction : divisor

  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // Both source enables must never be high together
  always @(negedge CLK) begin
    if (RST_N === 1'b1)
      check("both sources", {15'h0, USB_DIGITAL_EN & USB_ANALOG_EN}, 16'h0);
  end

  // Watchdog: the lock wait dominates, about 4200 cycles
  initial begin
    repeat (30000) @(posedge CLK);
    failures++;
    final_report();
  end

  initial begin
    seed = 32;
    {RST_N, CE, IO_WR, IO_RD} = 4'b0100;
    IO_ADDR = 16'h0;
    IO_WDATA = 16'h0;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    RST_N = 1'b1;
    // Reset values of all three registers and the enables
    check("digital en", {15'h0, USB_DIGITAL_EN}, 16'h1);
    check("analog en", {15'h0, USB_ANALOG_EN}, 16'h0);
    rd(SYSCTL_ADDR, r);
    check("control reset", r, 16'h0000);
    rd(USB_SEL_ADDR, r);
    check("select reset", r, 16'h0004);
    rd(ANALOG_PHASE_LOOP_MODE_ADDR, r);
    check("mode reset", r, 16'h0000);
    $display("test reset done");
    // Every divide code, with random junk in the reserved bits
    for (i = 0; i < 8; i++) begin
      m = $random(seed);
      wr(SYSCTL_ADDR, {m[15:3], i[2:0]});
      rd(SYSCTL_ADDR, r);
      check("control read", r, {13'h0, i[2:0]});
      // Skip the restart period, then time one full period
      @(posedge EXT_CLOCK_OUT);
      @(posedge EXT_CLOCK_OUT);
      t0 = $realtime;
      @(posedge EXT_CLOCK_OUT);
      check("period", 16'(int'(($realtime - t0) / 25.0)), 16'(divisor(i[2:0])));
      check("loop outputs", {9'h0, ANALOG_PHASE_LOOP_LOOP_MULTIPLY_FIELD, ANALOG_PHASE_LOOP_DIV_SEL, ANALOG_PHASE_LOOP_VCO_ON,
        ANALOG_PHASE_LOOP_MULTIPLY_MODE}, 16'h0);
    end
    $display("test divide done");
    // Frozen write, neighbour port write, unmapped read
    @(negedge CLK);
    CE = 1'b0;
    wr(SYSCTL_ADDR, 16'h0002);
    CE = 1'b1;
    wr(16'h07fc, 16'h0001);
    rd(SYSCTL_ADDR, r);
    check("control kept", r, 16'h0007);
    rd(16'h07fc, r);
    check("unmapped read", r, 16'h0000);
    // Select analog without lock keeps the digital loop
    // zeros in reserved bits
    wr(USB_SEL_ADDR, 16'h0001);
    repeat (3) @(negedge CLK);
    rd(USB_SEL_ADDR, r);
    check("select unlocked", r, 16'h0005);
    $display("test select done");
    // Enter multiply mode with random loop fields
    m = $random(seed);
    wr(ANALOG_PHASE_LOOP_MODE_ADDR, {m[15:11], 8'h00, m[2], 2'b10});
    check("loop_multiply_field out", {11'h0, ANALOG_PHASE_LOOP_LOOP_MULTIPLY_FIELD, ANALOG_PHASE_LOOP_DIV_SEL}, {11'h0, m[15:11]});
    check("mode out", {14'h0, ANALOG_PHASE_LOOP_MULTIPLY_MODE, ANALOG_PHASE_LOOP_VCO_ON}, 16'h0003);
    repeat (2) @(negedge CLK);
    rd(ANALOG_PHASE_LOOP_MODE_ADDR, c0);
    // Reads spaced exactly 16 cycles apart see one step
    repeat (14) @(negedge CLK);
    rd(ANALOG_PHASE_LOOP_MODE_ADDR, r);
    check("count step", {8'h0, r[10:3]}, {8'h0, c0[10:3] - 8'h01});
    for (k = 0; k < 3000 && r[0] !== 1'b1; k++)
      rd(ANALOG_PHASE_LOOP_MODE_ADDR, r);
    check("locked", r, {m[15:11], 8'h00, m[2], 2'b11});
    repeat (4) @(negedge CLK);
    rd(USB_SEL_ADDR, r);
    check("analog active", r, 16'h0003);
    check("analog en on", {15'h0, USB_ANALOG_EN}, 16'h1);
    $display("test lock done");
    // Return to the digital loop
    // zeros in reserved bits
    wr(USB_SEL_ADDR, 16'h0000);
    repeat (3) @(negedge CLK);
    rd(USB_SEL_ADDR, r);
    check("digital again", r, 16'h0004);
    check("digital en on", {15'h0, USB_DIGITAL_EN}, 16'h1);
    $display("test return done");
    final_report();
  end
endmodule : testbench

// File: hdl/cdu_clock_ctrl.sv
`timescale 1ns/1ps
module cdu_clock_ctrl
  import cdu_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [15:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [15:0] IO_WDATA,
  output logic [15:0] IO_RDATA,
  output logic EXT_CLOCK_OUT,
  output logic USB_DIGITAL_EN,
  output logic USB_ANALOG_EN,
  output logic [3:0] ANALOG_PHASE_LOOP_LOOP_MULTIPLY_FIELD,
  output logic ANALOG_PHASE_LOOP_DIV_SEL,
  output logic ANALOG_PHASE_LOOP_VCO_ON,
  output logic ANALOG_PHASE_LOOP_MULTIPLY_MODE
);
  // Register contents
  logic [2:0] output_clock_divide_field; // Output divide code
  logic usb_source_select;               // Requested USB source, 1 = analog
  logic digital_loop_active_flag;        // Digital loop drives the USB clock
  logic analog_loop_active_flag;         // Analog loop drives the USB clock
  logic [3:0] loop_multiply_field;       // Analog multiply factor less one
  logic div_factor_sel;                  // Analog divide factor select
  logic vco_on;                          // VCO forced on
  logic loop_multiply_field_mode;                       // Multiply mode
  logic [7:0] lock_count;                // Lock timer
  logic lock_stat;                       // Lock reached
  logic [3:0] prescale;                  // Reference divide by sixteen
  logic lock_tick;                       // One count interval elapsed
  logic want_analog;                     // Analog requested and locked
  logic mode_q;                          // Multiply mode as seen last enabled cycle
  logic [15:0] next_rdata;               // Read mux output

  cdu_div_if dif ();

  // Full 16-bit address compare shared by read and write decode
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction : hit

  assign dif.div_code = output_clock_divide_field;
  cdu_external_clock_output_div u_div (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .dif(dif)
  );
  assign EXT_CLOCK_OUT = dif.div_clk;

  // System control write; only the divide field has storage
  // fixed port decode
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      output_clock_divide_field <= DIV_RESET;
    end else if (CE && IO_WR && hit(IO_ADDR, SYSCTL_ADDR)) begin
      output_clock_divide_field <= IO_WDATA[DIV_LSB +: DIV_W];
    end
  end

  // USB source select write
  // select bit storage
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      usb_source_select <= SEL_RESET;
    end else if (CE && IO_WR && hit(IO_ADDR, USB_SEL_ADDR)) begin
      usb_source_select <= IO_WDATA[SEL_BIT];
    end
  end

  // Analog loop configuration fields
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      loop_multiply_field <= LOOP_MULTIPLY_FIELD_RESET;
      div_factor_sel <= 1'b0;
      vco_on <= 1'b0;
      loop_multiply_field_mode <= 1'b0;
    end else if (CE && IO_WR && hit(IO_ADDR, ANALOG_PHASE_LOOP_MODE_ADDR)) begin
      loop_multiply_field <= IO_WDATA[LOOP_MULTIPLY_FIELD_LSB +: 4];
      div_factor_sel <= IO_WDATA[DIVF_BIT];
      vco_on <= IO_WDATA[ON_BIT];
      loop_multiply_field_mode <= IO_WDATA[MODE_BIT];
    end
  end

  // Reference prescaler; held at zero outside multiply mode so each lock load starts it from zero
  assign lock_tick = (prescale == PRESCALE_LAST);
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prescale <= 4'h0;
    end else if (CE) begin
      if (!loop_multiply_field_mode) begin
        prescale <= 4'h0;
      end else begin
        prescale <= prescale + 4'h1;
      end
    end
  end

  // Mode seen last cycle; a rising mode starts the lock timer
  // Kept under the enable so a frozen cycle cannot fake a mode edge
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q <= 1'b0;
    end else if (CE) begin
      mode_q <= loop_multiply_field_mode;
    end
  end

  // Lock timer: loads on entry to multiply mode, counts down, then flags lock
  // lock countdown
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_count <= COUNT_RESET;
      lock_stat <= 1'b0;
    end else if (CE) begin
      if (!loop_multiply_field_mode) begin
        // Leaving multiply mode drops lock at once
        lock_count <= COUNT_RESET;
        lock_stat <= 1'b0;
      end else if (prescale == 4'h0 && !lock_stat && lock_count == 8'h00 && !mode_q) begin
        lock_count <= LOCK_LOAD;
      end else if (lock_count != 8'h00) begin
        if (lock_tick) begin
          lock_count <= lock_count - 8'h01;
        end
      end else begin
        lock_stat <= 1'b1;
      end
    end
  end

  // Analog takes over only once it is both requested and locked
  assign want_analog = usb_source_select && lock_stat;

  // Break-before-make switch: old source off one cycle, then new source on
  // digital after reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      digital_loop_active_flag <= 1'b1;
      analog_loop_active_flag <= 1'b0;
    end else if (CE) begin
      if (want_analog) begin
        if (digital_loop_active_flag) begin
          digital_loop_active_flag <= 1'b0;
        end else begin
          analog_loop_active_flag <= 1'b1;
        end
      end else begin
        if (analog_loop_active_flag) begin
          analog_loop_active_flag <= 1'b0;
        end else begin
          digital_loop_active_flag <= 1'b1;
        end
      end
    end
  end

  assign USB_DIGITAL_EN = digital_loop_active_flag;
  assign USB_ANALOG_EN = analog_loop_active_flag;
  assign ANALOG_PHASE_LOOP_LOOP_MULTIPLY_FIELD = loop_multiply_field;
  assign ANALOG_PHASE_LOOP_DIV_SEL = div_factor_sel;
  assign ANALOG_PHASE_LOOP_MULTIPLY_MODE = loop_multiply_field_mode;
  // VCO runs when forced on or in multiply mode
  assign ANALOG_PHASE_LOOP_VCO_ON = vco_on | loop_multiply_field_mode;

  // Read mux; reserved and unmapped bits read zero
  always_comb begin
    next_rdata = 16'h0000;
    if (hit(IO_ADDR, SYSCTL_ADDR)) begin
      next_rdata[DIV_LSB +: DIV_W] = output_clock_divide_field;
    end else if (hit(IO_ADDR, USB_SEL_ADDR)) begin
      next_rdata[SEL_BIT] = usb_source_select;
      next_rdata[ANA_FLAG_BIT] = analog_loop_active_flag;
      next_rdata[DIG_FLAG_BIT] = digital_loop_active_flag;
    end else if (hit(IO_ADDR, ANALOG_PHASE_LOOP_MODE_ADDR)) begin
      next_rdata[LOOP_MULTIPLY_FIELD_LSB +: 4] = loop_multiply_field;
      next_rdata[DIVF_BIT] = div_factor_sel;
      next_rdata[COUNT_LSB +: 8] = lock_count;
      next_rdata[ON_BIT] = vco_on;
      next_rdata[MODE_BIT] = loop_multiply_field_mode;
      next_rdata[STAT_BIT] = lock_stat;
    end
  end

  // Read data is registered: valid the cycle after the read strobe
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IO_RDATA <= 16'h0000;
    end else if (CE && IO_RD) begin
      IO_RDATA <= next_rdata;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sysctl_write_a: assert property (CE && IO_WR && IO_ADDR == 16'h07fd
    |=> output_clock_divide_field == $past(IO_WDATA[2:0])) else $error("divide write lost");
  sysctl_reserved_a: assert property (CE && IO_RD && IO_ADDR == 16'h07fd
    |=> IO_RDATA[15:3] == 13'h0000) else $error("reserved bits not zero");
  divider_isolated_a: assert property (CE && IO_WR && IO_ADDR == 16'h07fd
    |=> $stable(loop_multiply_field_mode) && $stable(usb_source_select)) else $error("divide write leaked");
  select_read_a: assert property (CE && IO_RD && IO_ADDR == USB_SEL_ADDR
    |=> IO_RDATA[0] == $past(usb_source_select) && IO_RDATA[2] == $past(USB_DIGITAL_EN)
    && IO_RDATA[1] == $past(USB_ANALOG_EN)) else $error("select status read wrong");
  one_source_a: assert property (!(USB_DIGITAL_EN && USB_ANALOG_EN))
    else $error("both USB sources active");
  analog_locked_a: assert property ($rose(USB_ANALOG_EN) |-> $past(want_analog))
    else $error("analog active before lock");
  digital_default_a: assert property (CE && !usb_source_select && !USB_ANALOG_EN
    |=> USB_DIGITAL_EN) else $error("digital source not restored");
  lock_count_a: assert property (CE && loop_multiply_field_mode && lock_tick && lock_count > 8'h01
    |=> lock_count == $past(lock_count) - 8'h01) else $error("lock count step wrong");
  lock_done_a: assert property (CE && loop_multiply_field_mode && lock_count == 8'h00 && lock_stat
    && usb_source_select |-> ##[0:2] USB_ANALOG_EN) else $error("lock did not switch");
  select_write_a: assert property (CE && IO_WR && IO_ADDR == USB_SEL_ADDR
    |=> usb_source_select == $past(IO_WDATA[0])) else $error("select write lost");

  to_analog_c: cover property (USB_DIGITAL_EN ##[1:8] USB_ANALOG_EN);
  back_digital_c: cover property (USB_ANALOG_EN ##[1:8] USB_DIGITAL_EN);
  lock_reached_c: cover property ($rose(lock_stat));
endmodule : cdu_clock_ctrl

// File: hdl/cdu_div_if.sv
`timescale 1ns/1ps
// Carries the divide code to the output divider and the divided clock back
interface cdu_div_if;
  logic [2:0] div_code; // Current divide field
  logic div_clk;        // Divided clock for the output pin
  modport ctrl (output div_code, input div_clk);
  modport div (input div_code, output div_clk);
endinterface : cdu_div_if

// File: hdl/cdu_external_clock_output_div.sv
`timescale 1ns/1ps
module cdu_external_clock_output_div
  import cdu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  cdu_div_if.div dif
);
  logic [2:0] cnt;      // Cycles spent in the current half period
  logic tog;            // Toggling output for even divides
  logic [2:0] code_q;   // Code seen last cycle, to restart on change
  logic half_done;      // Half period complete

  assign half_done = (cnt == dif.div_code - 3'h1);

  // Half period counter; a new code restarts it so no runt period lingers
  // half period counting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 3'h0;
      tog <= 1'b0;
      code_q <= DIV_RESET;
    end else if (ce) begin
      code_q <= dif.div_code;
      if (dif.div_code != code_q || dif.div_code == 3'h0) begin
        cnt <= 3'h0;
      end else if (half_done) begin
        // Toggle every code cycles: divide by twice the code
        cnt <= 3'h0;
        tog <= ~tog;
      end else begin
        cnt <= cnt + 3'h1;
      end
    end
  end

  // Code zero passes the CPU clock straight through, as no flop can divide by one
  // divide by one path
  assign dif.div_clk = (dif.div_code == 3'h0) ? clk : tog;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  div_toggle_a: assert property (ce && dif.div_code != 3'h0 && dif.div_code == code_q && half_done
    |=> tog != $past(tog)) else $error("divider missed a toggle");
  div_bound_a: assert property (ce && dif.div_code != 3'h0 && dif.div_code == code_q
    |-> cnt < dif.div_code) else $error("half period counter overran");
  div_pass_a: assert property (dif.div_code == 3'h0 |-> dif.div_clk == clk)
    else $error("divide by one not passed through");
  div_by14_c: cover property (dif.div_code == 3'h7 && half_done && ce);
endmodule : cdu_external_clock_output_div

// File: hdl/cdu_pkg.sv
package cdu_pkg;
  // Port addresses in the I/O space
  localparam logic [15:0] SYSCTL_ADDR = 16'h07fd;
  localparam logic [15:0] USB_SEL_ADDR = 16'h07fe;
  localparam logic [15:0] ANALOG_PHASE_LOOP_MODE_ADDR = 16'h07ff;
  // System control layout
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 3;
  localparam logic [2:0] DIV_RESET = 3'h0;
  // USB selection and status layout
  localparam int SEL_BIT = 0;
  localparam int ANA_FLAG_BIT = 1;
  localparam int DIG_FLAG_BIT = 2;
  localparam logic SEL_RESET = 1'b0;
  // Analog loop mode layout
  localparam int STAT_BIT = 0;
  localparam int MODE_BIT = 1;
  localparam int ON_BIT = 2;
  localparam int COUNT_LSB = 3;
  localparam int DIVF_BIT = 11;
  localparam int LOOP_MULTIPLY_FIELD_LSB = 12;
  localparam logic [3:0] LOOP_MULTIPLY_FIELD_RESET = 4'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // Value the lock counter starts from when multiply mode is entered
  localparam logic [7:0] LOCK_LOAD = 8'hff;
  // Reference clock prescale for the lock counter
  localparam logic [3:0] PRESCALE_LAST = 4'hf;
endpackage : cdu_pkg
